// ==== mpts_defs.svh ====
// What the document requires of this block and its host
// R01 - power-on needs toggle line held low at least 1 s, then released
// R02 - below 3.4 V supply the power-on low pulse is at least 5 s
// R03 - monitor rises during start-up; host waits 900 ms after it rises; the block waits only 200 ms before serial_ready
// R04 - host sends no serial data during first 200 ms of start-up
// R05 - power-off needs toggle line low at least 2 s, then released
// R06 - shutdown begins only after the toggle line is released
// R07 - monitor drops low once power-off is complete
// R08 - software or pin power-off always sends a network detach first
// R09 - unconditional restart needs restart line low at least 200 ms
// R10 - restart skips detach; host uses it only in emergencies
// R11 - host and board always provide the restart path
// R12 - toggle line is open-collector only, pulled up inside
// R13 - restart line is open-collector only, no push-pull
// R14 - host keeps digital pins non-high while module off or changing
// R15 - host waits for monitor high plus settle before serial traffic; serial_ready rises 200 ms after the monitor, MPTS_SETTLE_MS is unused
`ifndef MPTS_DEFS_SVH
`define MPTS_DEFS_SVH

// ----------------------------------------------------------------
// timing, in milliseconds as printed
// ----------------------------------------------------------------
`define MPTS_CLK_KHZ         200000
`define MPTS_ON_MS           1000
`define MPTS_OFF_MS          2000
`define MPTS_RESTART_MS      200
`define MPTS_SERIAL_HOLD_MS  200
`define MPTS_SETTLE_MS       900

// ----------------------------------------------------------------
// cycle counts derived from the rate
// ----------------------------------------------------------------
`define MPTS_CYC(ms)         ((ms) * `MPTS_CLK_KHZ)
`define MPTS_CNT_W           32

`endif

// ==== mpts_pkg.sv ====
package mpts_pkg;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MPTS_OFF,
    MPTS_ON_PRESS,
    MPTS_STARTING,
    MPTS_RUNNING,
    MPTS_OFF_PRESS,
    MPTS_OFF_WAIT_RELEASE,
    MPTS_DETACHING
  } mpts_state_type;

endpackage : mpts_pkg

// ==== mpts_sequencer.sv ====
`timescale 1ns/1ps
`include "mpts_defs.svh"

module mpts_sequencer #(
  parameter logic [31:0] ON_CYCLES      = 32'(`MPTS_CYC(`MPTS_ON_MS)),
  parameter logic [31:0] OFF_CYCLES     = 32'(`MPTS_CYC(`MPTS_OFF_MS)),
  parameter logic [31:0] RESTART_CYCLES = 32'(`MPTS_CYC(`MPTS_RESTART_MS)),
  parameter logic [31:0] SERIAL_CYCLES  = 32'(`MPTS_CYC(`MPTS_SERIAL_HOLD_MS))
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic power_toggle_b,
  input  wire logic restart_b,
  input  wire logic software_shutdown_command,
  input  wire logic detach_done,
  output logic      power_on_monitor,
  output logic      serial_ready,
  output logic      detach_request,
  output logic      core_enable
);

  // ----------------------------------------------------------------
  // state and next values
  // ----------------------------------------------------------------
  mpts_pkg::mpts_state_type state;
  mpts_pkg::mpts_state_type next_state;
  logic [31:0]              press_cnt;
  logic [31:0]              next_press_cnt;
  logic [31:0]              rst_cnt;
  logic [31:0]              next_rst_cnt;
  logic [31:0]              start_cnt;
  logic [31:0]              next_start_cnt;
  logic                     next_power_on_monitor;
  logic                     next_serial_ready;
  logic                     next_detach_request;
  logic                     next_core_enable;
  logic                     restart_hit;
  logic                     start_clear;

  // ----------------------------------------------------------------
  // counter helpers
  // ----------------------------------------------------------------
  // saturating increment, a held line never wraps the count
  function automatic logic [31:0] mpts_inc(input logic [31:0] v);
    mpts_inc = (v == 32'hFFFFFFFF) ? v : v + 32'h00000001;
  endfunction : mpts_inc

  // true on the edge that completes lim cycles; a saturated
  // count stays reached instead of wrapping back to zero
  function automatic logic mpts_reached(input logic [31:0] v, input logic [31:0] lim);
    mpts_reached = (v == 32'hFFFFFFFF) || (v + 32'h00000001 >= lim);
  endfunction : mpts_reached

  // ----------------------------------------------------------------
  // restart pulse measurement
  // ----------------------------------------------------------------
  // restart acts on release after a long enough low pulse
  always_comb begin
    next_rst_cnt = restart_b ? 32'h00000000 : mpts_inc(rst_cnt);
    // R09 restart pulse length
    restart_hit  = restart_b && (rst_cnt >= RESTART_CYCLES);
  end

  // restart counter register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rst_cnt <= 32'h00000000;
    end else begin
      rst_cnt <= next_rst_cnt;
    end
  end

  // ----------------------------------------------------------------
  // toggle press measurement
  // ----------------------------------------------------------------
  // low-time counter, cleared whenever the toggle line is released
  always_comb begin
    next_press_cnt = power_toggle_b ? 32'h00000000 : mpts_inc(press_cnt);
  end

  // press counter register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      press_cnt <= 32'h00000000;
    end else begin
      press_cnt <= next_press_cnt;
    end
  end

  // ----------------------------------------------------------------
  // power sequencer
  // ----------------------------------------------------------------
  // next state and outputs
  always_comb begin
    // hold everything but the detach_request and start_clear pulses unless a branch below moves it
    next_state            = state;
    start_clear           = 1'b0;
    next_power_on_monitor = power_on_monitor;
    next_serial_ready     = serial_ready;
    next_detach_request   = 1'b0;
    next_core_enable      = core_enable;
    unique case (state)
      // powered down, waiting for a long enough press
      mpts_pkg::MPTS_OFF: begin
        next_power_on_monitor = 1'b0;
        next_serial_ready     = 1'b0;
        next_core_enable      = 1'b0;
        // R01 power-on press
        if (!power_toggle_b && mpts_reached(press_cnt, ON_CYCLES)) begin
          next_state = mpts_pkg::MPTS_ON_PRESS;
        end
      end
      // press long enough, start-up begins on release
      mpts_pkg::MPTS_ON_PRESS: begin
        if (power_toggle_b) begin
          // R03 monitor rises
          next_state            = mpts_pkg::MPTS_STARTING;
          next_power_on_monitor = 1'b1;
          next_core_enable      = 1'b1;
          start_clear           = 1'b1;
        end
      end
      // serial hold-off after the monitor rises
      mpts_pkg::MPTS_STARTING: begin
        // R04 serial hold-off
        if (mpts_reached(start_cnt, SERIAL_CYCLES)) begin
          next_serial_ready = 1'b1;
          next_state        = mpts_pkg::MPTS_RUNNING;
        end
      end
      // powered, watching for a shutdown request
      mpts_pkg::MPTS_RUNNING: begin
        // R08 software shutdown detaches first
        if (software_shutdown_command) begin
          next_state = mpts_pkg::MPTS_DETACHING;
          next_detach_request = 1'b1;
        end else if (!power_toggle_b) begin
          next_state = mpts_pkg::MPTS_OFF_PRESS;
        end
      end
      // off press being measured
      mpts_pkg::MPTS_OFF_PRESS: begin
        if (power_toggle_b) begin
          next_state = mpts_pkg::MPTS_RUNNING; // short press ignored
        // R05 power-off press
        end else if (mpts_reached(press_cnt, OFF_CYCLES)) begin
          next_state = mpts_pkg::MPTS_OFF_WAIT_RELEASE;
        end
      end
      // long press seen, shutdown waits for release
      mpts_pkg::MPTS_OFF_WAIT_RELEASE: begin
        // R06 wait for release
        if (power_toggle_b) begin
          next_state          = mpts_pkg::MPTS_DETACHING;
          next_detach_request = 1'b1;
        end
      end
      // network detach in flight
      mpts_pkg::MPTS_DETACHING: begin
        // R08 detach before stop
        next_serial_ready = 1'b0;
        if (detach_done) begin
          // R07 monitor falls when off
          next_state            = mpts_pkg::MPTS_OFF;
          next_power_on_monitor = 1'b0;
          next_core_enable      = 1'b0;
        end
      end
    endcase
    // unconditional restart skips detach and restarts the core;
    // it acts on release of the line and is ignored while powered
    // down, so a stuck module comes back without any detach
    // R09 R10 restart on release, no detach
    if (restart_hit && state != mpts_pkg::MPTS_OFF && state != mpts_pkg::MPTS_ON_PRESS) begin
      next_state            = mpts_pkg::MPTS_STARTING;
      next_power_on_monitor = 1'b1;
      next_core_enable      = 1'b1;
      next_serial_ready     = 1'b0;
      next_detach_request   = 1'b0;
      start_clear           = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // start-up counter
  // ----------------------------------------------------------------
  // counts cycles in start-up, cleared on every start or restart
  always_comb begin
    if (start_clear) begin
      next_start_cnt = 32'h00000000;
    end else if (state == mpts_pkg::MPTS_STARTING) begin
      next_start_cnt = mpts_inc(start_cnt);
    end else begin
      next_start_cnt = start_cnt;
    end
  end

  // start-up counter register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      start_cnt <= 32'h00000000;
    end else begin
      start_cnt <= next_start_cnt;
    end
  end

  // ----------------------------------------------------------------
  // sequencer registers
  // ----------------------------------------------------------------
  // state and output registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state            <= mpts_pkg::MPTS_OFF;
      power_on_monitor <= 1'b0;
      serial_ready     <= 1'b0;
      detach_request   <= 1'b0;
      core_enable      <= 1'b0;
    end else begin
      state            <= next_state;
      power_on_monitor <= next_power_on_monitor;
      serial_ready     <= next_serial_ready;
      detach_request   <= next_detach_request;
      core_enable      <= next_core_enable;
    end
  end

endmodule : mpts_sequencer

// ==== mpts_sequencer_asserts.sv ====
`timescale 1ns/1ps
module mpts_sequencer_asserts #(
  parameter int SERIAL_CYCLES  = 10,
  parameter int RESTART_CYCLES = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic power_toggle_b,
  input wire logic restart_b,
  input wire logic software_shutdown_command,
  input wire logic detach_done,
  input wire logic power_on_monitor,
  input wire logic serial_ready,
  input wire logic detach_request,
  input wire logic core_enable
);
  localparam int SW = SERIAL_CYCLES - 1;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  int low_run;
  // consecutive low cycles of the restart line
  always_ff @(posedge clk) begin
    if (!rst_b) low_run <= 0;
    else low_run <= restart_b ? 0 : low_run + 1;
  end
  release_first_a: assert property (detach_request |-> $past(power_toggle_b))
    else $error("detach while toggle held");
  serial_hold_a: assert property ($rose(power_on_monitor) |-> ##SW !serial_ready ##1 serial_ready)
    else $error("serial ready off time");
  off_confirm_a: assert property ($fell(power_on_monitor) && $past(restart_b) |-> $past(detach_done))
    else $error("monitor fell without detach");
  detach_first_a: assert property ($rose(software_shutdown_command) && serial_ready && power_toggle_b
    && restart_b |=> detach_request)
    else $error("no detach after shutdown");
  core_tracks_a: assert property (core_enable == power_on_monitor)
    else $error("core enable differs from monitor");
  restart_boot_a: assert property ($rose(restart_b) && low_run >= RESTART_CYCLES && power_on_monitor
    |=> power_on_monitor && !serial_ready && !detach_request)
    else $error("restart did not reboot cleanly");
endmodule : mpts_sequencer_asserts
bind mpts_sequencer mpts_sequencer_asserts #(.SERIAL_CYCLES(SERIAL_CYCLES), .RESTART_CYCLES(RESTART_CYCLES))
  u_chk (.clk(clk), .rst_b(rst_b),
  .power_toggle_b(power_toggle_b), .restart_b(restart_b), .software_shutdown_command(software_shutdown_command),
  .detach_done(detach_done), .power_on_monitor(power_on_monitor), .serial_ready(serial_ready),
  .detach_request(detach_request), .core_enable(core_enable));

// ==== mpts_host_model.sv ====
`timescale 1ns/1ps
module mpts_host_model (
  input  wire logic clk,
  input  wire logic toggle_pull,
  input  wire logic restart_pull,
  input  wire logic slow,
  input  wire logic detach_request,
  output logic      power_toggle_b,
  output logic      restart_b,
  output logic      detach_done
);
  int wait_cnt = -1;
  assign power_toggle_b = !toggle_pull;
  assign restart_b      = !restart_pull;
  // network answers detach, prompt or slow
  always @(posedge clk) begin
    detach_done <= (wait_cnt == 0);
    if (detach_request) wait_cnt <= slow ? 30 : 2;
    else if (wait_cnt >= 0) wait_cnt <= wait_cnt - 1;
  end
endmodule : mpts_host_model

// ==== mpts_sequencer_tb.sv ====
`timescale 1ns/1ps
module mpts_sequencer_tb;
  logic clk = 1'b0, rst_b = 1'b0, tp = 1'b0, rp = 1'b0, slow = 1'b0, sw = 1'b0;
  logic ptb, rsb, done, mon, rdy, det, core;
  int   fails = 0, comparisons = 0, dets = 0, d0;
  always #2.5 clk = ~clk;
  always @(posedge clk) if (det) dets++;
  mpts_sequencer #(.ON_CYCLES(32'h14), .OFF_CYCLES(32'h28), .RESTART_CYCLES(32'h8), .SERIAL_CYCLES(32'hA)) uut (
    .clk(clk), .rst_b(rst_b), .power_toggle_b(ptb), .restart_b(rsb), .software_shutdown_command(sw),
    .detach_done(done), .power_on_monitor(mon), .serial_ready(rdy), .detach_request(det), .core_enable(core));
  mpts_host_model host (.clk(clk), .toggle_pull(tp), .restart_pull(rp), .slow(slow), .detach_request(det),
    .power_toggle_b(ptb), .restart_b(rsb), .detach_done(done));
  task automatic chk(input string name, input logic seen, input logic exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %b seen %b", name, exp, seen);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic press(input int n, input bit rl);
    if (rl) rp = 1'b1; else tp = 1'b1;
    tick(n);
    rp = 1'b0;
    tp = 1'b0;
  endtask : press
  task automatic t_on;
    press(19, 0);
    tick(3);
    chk("mon", mon, 1'b0);
    press(20, 0);
    tick(2);
    chk("mon", mon, 1'b1);
    chk("core", core, 1'b1);
    chk("rdy", rdy, 1'b0);
    tick(10);
    chk("rdy", rdy, 1'b1);
  endtask : t_on
  task automatic t_pin_off;
    d0 = dets;
    press(39, 0);
    tick(3);
    chk("det", dets == d0, 1'b1);
    slow = 1'b1;
    tp = 1'b1;
    tick(45);
    chk("det", dets == d0, 1'b1);
    tp = 1'b0;
    tick(3);
    chk("det", dets == d0 + 1, 1'b1);
    chk("mon", mon, 1'b1);
    tick(40);
    chk("mon", mon, 1'b0);
    chk("core", core, 1'b0);
  endtask : t_pin_off
  task automatic t_sw_off;
    slow = 1'b0;
    d0 = dets;
    sw = 1'b1;
    tick(1);
    sw = 1'b0;
    tick(2);
    chk("det", dets == d0 + 1, 1'b1);
    tick(6);
    chk("mon", mon, 1'b0);
    chk("core", core, 1'b0);
  endtask : t_sw_off
  task automatic t_long_on;
    tp = 1'b1;
    tick(100);
    chk("mon", mon, 1'b0);
    // long low-supply press still powers on
    tp = 1'b0;
    tick(2);
    chk("mon", mon, 1'b1);
    tick(10);
    chk("rdy", rdy, 1'b1);
  endtask : t_long_on
  task automatic t_restart;
    press(8, 1);
    tick(3);
    chk("mon", mon, 1'b0);
    t_on();
    press(7, 1);
    tick(2);
    chk("rdy", rdy, 1'b1);
    d0 = dets;
    press(8, 1);
    tick(2);
    chk("mon", mon, 1'b1);
    chk("rdy", rdy, 1'b0);
    tick(12);
    chk("rdy", rdy, 1'b1);
    chk("det", dets == d0, 1'b1);
  endtask : t_restart
  task automatic wrap_up;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    tick(5);
    rst_b = 1'b1;
    t_on();
    t_pin_off();
    t_on();
    t_sw_off();
    t_restart();
    t_sw_off();
    t_long_on();
    wrap_up();
  end
  initial begin
    #20000;
    fails++;
    wrap_up();
  end
endmodule : mpts_sequencer_tb
